// file: sld_regs.vh
`ifndef SLD_REGS_VH
`define SLD_REGS_VH

// register byte offsets on the apb bus
`define SLD_OFS_CTRL 12'h000
`define SLD_OFS_ADDR 12'h004
`define SLD_OFS_DATA 12'h008
`define SLD_OFS_SBPC 12'h00C

// display_control fields
`define SLD_CTRL_BIAS 7
`define SLD_CTRL_DUTY_HI 6
`define SLD_CTRL_DUTY_LO 5
`define SLD_CTRL_EN 4
`define SLD_CTRL_TYPE 2
`define SLD_CTRL_FRM_HI 1
`define SLD_CTRL_FRM_LO 0
`define SLD_CTRL_MASK 8'hF7

// display_ram_address and data buffer fields
`define SLD_ADDR_W 5
`define SLD_ADDR_MASK 8'h1F
`define SLD_DATA_MASK 8'h0F

// system_booster_pll_control fields
`define SLD_SBPC_BF_HI 2
`define SLD_SBPC_BF_LO 1

// reset values
`define SLD_CTRL_RST 8'h00
`define SLD_ADDR_RST 5'h00
`define SLD_SBPC_RST 8'h00
`define SLD_RAM_RST 4'h0

// geometry
`define SLD_NSEG 32
`define SLD_NCOM 4

// per-line counts in sub-clock ticks
`define SLD_L2_0 9'h100
`define SLD_L2_1 9'h118
`define SLD_L2_2 9'h130
`define SLD_L2_3 9'h0E8
`define SLD_L3_0 9'h0AC
`define SLD_L3_1 9'h0BC
`define SLD_L3_2 9'h0CC
`define SLD_L3_3 9'h09C
`define SLD_L4_0 9'h080
`define SLD_L4_1 9'h08C
`define SLD_L4_2 9'h098
`define SLD_L4_3 9'h074

// drive level codes: ground, first, second, top lcd level
`define SLD_LV0 2'h0
`define SLD_LV1 2'h1
`define SLD_LV2 2'h2
`define SLD_LV3 2'h3

// index of the last common scanned per duty
`define SLD_COM2 2'h1
`define SLD_COMMON_OUTPUT_3 2'h2
`define SLD_COM4 2'h3

`endif

// file: sld_segment_lcd.v
// Function
// - drive 32 segments and 4 commons
// - display runs in every power mode
// - all timing from sub-clock ticks only
// - control bit 7 selects half or third bias
// - bits 6..5 select half, third, quarter duty
// - bit 4 enables; disabled holds segment and common outputs ground
// - bit 2 selects A or B waveform
// - bits 1..0 select per-line count
// - address bits 7..5 read zero
// - address bits 4..0 pick segment 0..31
// - data bit n is dot on common n
// - booster clock sub-clock divided 1/4/8/16
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "sld_regs.vh"

module sld_segment_lcd (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_sub_clk,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output wire o_pslverr,
  output reg [31:0] o_prdata,
  output wire [63:0] o_seg_level,
  output wire [7:0] o_com_level,
  output reg o_booster_clk
);

////////////////////////////////////////////////////////////////////////////////
// reset release

reg rst_meta_n;
reg rst_n;

always @(posedge i_sys_clk or negedge i_arst_n) begin
  if (!i_arst_n) begin
    rst_meta_n <= 1'b0;
    rst_n <= 1'b0;
  end else begin
    rst_meta_n <= 1'b1;
    rst_n <= rst_meta_n;
  end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave

reg [7:0] ctrl;
reg [`SLD_ADDR_W-1:0] ram_addr;
reg [7:0] sbpc;
reg [3:0] ram [0:`SLD_NSEG-1];

wire sel_ctrl = (i_paddr == `SLD_OFS_CTRL);
wire sel_addr = (i_paddr == `SLD_OFS_ADDR);
wire sel_data = (i_paddr == `SLD_OFS_DATA);
wire sel_sbpc = (i_paddr == `SLD_OFS_SBPC);
wire mapped = sel_ctrl | sel_addr | sel_data | sel_sbpc;
wire setup = i_psel & ~i_penable;
wire wr_en = i_psel & i_penable & i_pwrite & mapped;
wire wr_ctrl = wr_en & sel_ctrl;
wire wr_addr = wr_en & sel_addr;
wire wr_data = wr_en & sel_data;
wire wr_sbpc = wr_en & sel_sbpc;

// zero wait states; read data is fetched in the setup cycle so it comes from a flop
assign o_pready = 1'b1;
assign o_pslverr = i_psel & i_penable & ~mapped;

reg [31:0] next_prdata;

// read mux; the low byte carries the register, upper bits read zero
always @* begin
  next_prdata = 32'h0000_0000;
  case (i_paddr)
    `SLD_OFS_CTRL: begin
      next_prdata = {24'h000000, ctrl};
    end
    `SLD_OFS_ADDR: begin
      next_prdata = {27'h0000000, ram_addr};
    end
    `SLD_OFS_DATA: begin
      next_prdata = {28'h0000000, ram[ram_addr]};
    end
    `SLD_OFS_SBPC: begin
      next_prdata = {24'h000000, sbpc};
    end
    default: begin
      next_prdata = 32'h0000_0000;
    end
  endcase
end

always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    o_prdata <= 32'h0000_0000;
  end else if (setup) begin
    o_prdata <= next_prdata;
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    ctrl <= `SLD_CTRL_RST;
  end else if (wr_ctrl) begin
    ctrl <= i_pwdata[7:0] & `SLD_CTRL_MASK;
  end
end

always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    ram_addr <= `SLD_ADDR_RST;
  end else if (wr_addr) begin
    ram_addr <= i_pwdata[`SLD_ADDR_W-1:0];
  end
end

// all eight bits are kept so software reads back what it wrote
always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    sbpc <= `SLD_SBPC_RST;
  end else if (wr_sbpc) begin
    sbpc <= i_pwdata[7:0];
  end
end

// display ram: one nibble per segment
genvar gi;
generate
  for (gi = 0; gi < `SLD_NSEG; gi = gi + 1) begin : g_ram
    always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ram[gi] <= `SLD_RAM_RST;
      end else if (wr_data && ram_addr == gi) begin
        ram[gi] <= i_pwdata[3:0];
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// sub-clock tick

// the pin is taken as synchronous; one flop gives the edge
reg sub_q;
wire sub_tick = i_sub_clk & ~sub_q;

always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    sub_q <= 1'b0;
  end else begin
    sub_q <= i_sub_clk;
  end
end

////////////////////////////////////////////////////////////////////////////////
// booster clock

reg [3:0] boost_cnt;
wire [1:0] bf_sel = {sbpc[`SLD_SBPC_BF_HI], sbpc[`SLD_SBPC_BF_LO]};
reg next_booster_clk;

always @* begin
  case (bf_sel)
    2'h0: next_booster_clk = sub_q;
    2'h1: next_booster_clk = boost_cnt[1];
    2'h2: next_booster_clk = boost_cnt[2];
    default: next_booster_clk = boost_cnt[3];
  endcase
end

always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    boost_cnt <= 4'h0;
    o_booster_clk <= 1'b0;
  end else begin
    if (sub_tick) begin
      boost_cnt <= boost_cnt + 4'h1;
    end
    o_booster_clk <= next_booster_clk;
  end
end

////////////////////////////////////////////////////////////////////////////////
// scan timing

wire bias_third = ctrl[`SLD_CTRL_BIAS];
wire enable = ctrl[`SLD_CTRL_EN];
wire type_b = ctrl[`SLD_CTRL_TYPE];
wire [1:0] duty = {ctrl[`SLD_CTRL_DUTY_HI], ctrl[`SLD_CTRL_DUTY_LO]};
wire [1:0] frm = {ctrl[`SLD_CTRL_FRM_HI], ctrl[`SLD_CTRL_FRM_LO]};

reg [1:0] last_com;
reg [8:0] line_len;

always @* begin
  case (duty)
    2'h0: last_com = `SLD_COM2;
    2'h1: last_com = `SLD_COMMON_OUTPUT_3;
    default: last_com = `SLD_COM4;
  endcase
end

reg [8:0] len_half;
reg [8:0] len_third;
reg [8:0] len_quarter;

// one table per duty keeps each frame rate near the same value
always @* begin
  case (frm)
    2'h0: len_half = `SLD_L2_0;
    2'h1: len_half = `SLD_L2_1;
    2'h2: len_half = `SLD_L2_2;
    default: len_half = `SLD_L2_3;
  endcase
end

always @* begin
  case (frm)
    2'h0: len_third = `SLD_L3_0;
    2'h1: len_third = `SLD_L3_1;
    2'h2: len_third = `SLD_L3_2;
    default: len_third = `SLD_L3_3;
  endcase
end

always @* begin
  case (frm)
    2'h0: len_quarter = `SLD_L4_0;
    2'h1: len_quarter = `SLD_L4_1;
    2'h2: len_quarter = `SLD_L4_2;
    default: len_quarter = `SLD_L4_3;
  endcase
end

always @* begin
  case (duty)
    2'h0: line_len = len_half;
    2'h1: line_len = len_third;
    default: line_len = len_quarter;
  endcase
end

reg [8:0] tick_cnt;
reg [1:0] com_idx;
reg frame_pol;

wire line_end = sub_tick && (tick_cnt >= line_len - 9'h001);
wire frame_end = line_end && (com_idx >= last_com);

// no power-mode input exists: the scan only stops when software clears enable
always @(posedge i_sys_clk or negedge rst_n) begin
  if (!rst_n) begin
    tick_cnt <= 9'h000;
    com_idx <= 2'h0;
    frame_pol <= 1'b0;
  end else if (!enable) begin
    tick_cnt <= 9'h000;
    com_idx <= 2'h0;
    frame_pol <= 1'b0;
  end else if (sub_tick) begin
    if (line_end) begin
      tick_cnt <= 9'h000;
      com_idx <= frame_end ? 2'h0 : com_idx + 2'h1;
      if (frame_end) begin
        frame_pol <= ~frame_pol;
      end
    end else begin
      tick_cnt <= tick_cnt + 9'h001;
    end
  end
end

// A type flips inside each line, B type flips once per frame
wire pol = type_b ? frame_pol : (tick_cnt >= {1'b0, line_len[8:1]});

////////////////////////////////////////////////////////////////////////////////
// output levels

reg [1:0] com_lv [0:`SLD_NCOM-1];
reg [1:0] seg_lv [0:`SLD_NSEG-1];

generate
  for (gi = 0; gi < `SLD_NCOM; gi = gi + 1) begin : g_com
    wire used = (gi <= last_com);
    wire on_line = (com_idx == gi);
    reg [1:0] next_lv;
    always @* begin
      if (!enable || !used) begin
        next_lv = `SLD_LV0;
      end else if (on_line) begin
        next_lv = pol ? `SLD_LV0 : `SLD_LV3;
      end else if (bias_third) begin
        next_lv = pol ? `SLD_LV2 : `SLD_LV1;
      end else begin
        next_lv = `SLD_LV1;
      end
    end
    always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        com_lv[gi] <= `SLD_LV0;
      end else begin
        com_lv[gi] <= next_lv;
      end
    end
    assign o_com_level[2*gi+1:2*gi] = com_lv[gi];
  end
endgenerate

generate
  for (gi = 0; gi < `SLD_NSEG; gi = gi + 1) begin : g_seg
    wire dot_on = ram[gi][com_idx];
    reg [1:0] next_lv;
    always @* begin
      if (!enable) begin
        next_lv = `SLD_LV0;
      end else if (dot_on) begin
        next_lv = pol ? `SLD_LV3 : `SLD_LV0;
      end else if (bias_third) begin
        next_lv = pol ? `SLD_LV1 : `SLD_LV2;
      end else begin
        next_lv = pol ? `SLD_LV0 : `SLD_LV3;
      end
    end
    always @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        seg_lv[gi] <= `SLD_LV0;
      end else begin
        seg_lv[gi] <= next_lv;
      end
    end
    assign o_seg_level[2*gi+1:2*gi] = seg_lv[gi];
  end
endgenerate

endmodule // sld_segment_lcd

// file: sld_panel_model.sv
`timescale 1ns/1ps
module sld_panel_model (
  input wire i_clk,
  input wire i_clr,
  input wire [7:0] i_com,
  output reg [3:0] o_seen
);
  integer k;
  // a common at top level marks its row as scanned
  always @(posedge i_clk) begin
    for (k = 0; k < 4; k = k + 1) begin
      if (i_clr) o_seen[k] <= 1'b0;
      else if (i_com[2*k+:2] == 2'h3) o_seen[k] <= 1'b1;
    end
  end
endmodule // sld_panel_model

// file: sld_segment_lcd_assertions.sv
`timescale 1ns/1ps
module sld_segment_lcd_assertions (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_sub_clk,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire [63:0] o_seg_level,
  input wire [7:0] o_com_level,
  input wire o_booster_clk
);
  reg [7:0] ctl;
  reg [7:0] bst;
  reg [2:0] age;
  wire wr = i_psel && i_penable && i_pwrite;
  wire rd = i_psel && !i_penable && !i_pwrite;
  wire calm = age == 3'h7;
  wire [3:0] top = {o_com_level[7:6] == 2'h3, o_com_level[5:4] == 2'h3,
    o_com_level[3:2] == 2'h3, o_com_level[1:0] == 2'h3};
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // age skips the settling cycles after a mode change
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl <= 8'h00;
      bst <= 8'h00;
      age <= 3'h0;
    end else if (wr && i_paddr == 12'h000) begin
      ctl <= i_pwdata[7:0];
      age <= 3'h0;
    end else if (wr && i_paddr == 12'h00C) begin
      bst <= i_pwdata[7:0];
      age <= 3'h0;
    end else if (!calm) begin
      age <= age + 3'h1;
    end
  end
  ////////////////////////////////////////
  a_ctl_read: assert property (
    rd && i_paddr == 12'h000 |=> o_prdata == {24'h0, ctl & 8'hF7}) else $error("ctl read");
  a_addr_high: assert property (
    rd && i_paddr == 12'h004 |=> o_prdata[31:5] == 27'h0) else $error("addr high");
  a_data_high: assert property (
    rd && i_paddr == 12'h008 |=> o_prdata[31:4] == 28'h0) else $error("data high");
  a_seg_ground: assert property (
    calm && !ctl[4] |-> o_seg_level == 64'h0) else $error("seg ground");
  a_com_ground: assert property (
    calm && !ctl[4] |-> o_com_level == 8'h0) else $error("com ground");
  a_com_range: assert property (
    calm && !ctl[6] |-> o_com_level[7:6] == 2'h0 && (ctl[5] || o_com_level[5:4] == 2'h0))
    else $error("com range");
  a_one_select: assert property ($onehot0(top)) else $error("two commons");
  a_boost_full: assert property (
    calm && bst[2:1] == 2'h0 |-> o_booster_clk == $past(i_sub_clk, 2)) else $error("boost");
  c_data_write: cover property (wr && i_paddr == 12'h008);
  c_common_output_3: cover property (top[3]);
  c_enabled: cover property (calm && ctl[4]);
endmodule // sld_segment_lcd_assertions

bind sld_segment_lcd sld_segment_lcd_assertions u_chk (.i_sys_clk(i_sys_clk),
  .i_arst_n(i_arst_n), .i_sub_clk(i_sub_clk), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_seg_level(o_seg_level), .o_com_level(o_com_level), .o_booster_clk(o_booster_clk));

// file: sld_segment_lcd_tb.sv
`timescale 1ns/1ps
module sld_segment_lcd_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg sub = 1'b0;
  reg sel = 1'b0;
  reg en = 1'b0;
  reg wr = 1'b0;
  reg clr = 1'b1;
  reg [11:0] pa = 12'h000;
  reg [31:0] wd = 32'h0;
  reg [31:0] rd;
  reg er;
  wire rdy;
  wire serr;
  wire [31:0] prd;
  wire [63:0] seg;
  wire [7:0] com;
  wire [3:0] seen;
  integer err_count = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  integer j;
  integer t;
  reg b;
  reg [3:0] nib;
  wire bclk;
  always #4 clk = ~clk;
  // sub clock of eight system cycles keeps frames short enough to simulate
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sub <= cyc[2];
    if (cyc == 60000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  sld_segment_lcd dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_sub_clk(sub), .i_psel(sel),
    .i_penable(en), .i_pwrite(wr), .i_paddr(pa), .i_pwdata(wd), .o_pready(rdy),
    .o_pslverr(serr), .o_prdata(prd), .o_seg_level(seg), .o_com_level(com),
    .o_booster_clk(bclk));
  sld_panel_model panel (.i_clk(clk), .i_clr(clr), .i_com(com), .o_seen(seen));
  ////////////////////////////////////////
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      @(posedge clk);
      sel <= 1'b1;
      wr <= w;
      pa <= a;
      wd <= d;
      @(posedge clk);
      en <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prd;
      er = serr;
      sel <= 1'b0;
      en <= 1'b0;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b1, 12'h000, 32'hFF);
    apb(1'b0, 12'h000, 0);
    chk("ctl", 32'hF7, rd);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b0, 12'h004, 0);
    chk("adr", 32'h1F, rd);
    apb(1'b1, 12'h00C, 32'hFF);
    apb(1'b0, 12'h00C, 0);
    chk("bst", 32'hFF, rd);
    apb(1'b0, 12'h010, 0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("registers done");
    for (i = 0; i < 32; i = i + 1) begin
      apb(1'b1, 12'h004, i);
      apb(1'b1, 12'h008, {24'h0, 4'hF, i[3:0] ^ {4{i[4]}}});
    end
    for (i = 0; i < 32; i = i + 1) begin
      apb(1'b1, 12'h004, i);
      apb(1'b0, 12'h008, 0);
      chk("ram", {28'h0, i[3:0] ^ {4{i[4]}}}, rd);
    end
    $display("ram done");
    apb(1'b1, 12'h00C, 0);
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, 12'h000, {24'h0, i[0], i[1:0], 2'h2, i[0], 2'h3});
      clr <= 1'b1;
      repeat (8) @(posedge clk);
      clr <= 1'b0;
      repeat (8000) @(posedge clk);
      chk("scan", {28'h0, 4'hF >> (2 - i)}, {28'h0, seen});
    end
    // quarter duty, half bias, A type: a selected common at top puts on dots at ground
    for (i = 0; i < 4; i = i + 1) begin
      t = 0;
      @(negedge clk);
      while (com[2*i+:2] !== 2'h3 && t < 4000) begin
        @(negedge clk);
        t = t + 1;
      end
      chk("com_top", 32'h3, {30'h0, com[2*i+:2]});
      for (j = 0; j < 32; j = j + 1) begin
        nib = j[3:0] ^ {4{j[4]}};
        chk("dot", nib[i] ? 32'h0 : 32'h3, {30'h0, seg[2*j+:2]});
      end
    end
    apb(1'b1, 12'h000, 0);
    repeat (8) @(posedge clk);
    chk("gnd", 0, seg[31:0] | seg[63:32] | {24'h0, com});
    $display("scan done");
    // sub clock has 80 periods in 640 cycles
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 12'h00C, {29'h0, i[1:0], 1'b0});
      repeat (40) @(posedge clk);
      @(negedge clk);
      b = bclk;
      t = 0;
      repeat (640) begin
        @(negedge clk);
        if (bclk && !b) begin
          t = t + 1;
        end
        b = bclk;
      end
      chk("boost", (i == 0) ? 80 : (40 >> i), t);
    end
    $display("booster done");
    conclude;
  end
endmodule // sld_segment_lcd_tb
